//--- hdl/epg_regs.svh
// register offsets, field positions and reset values of the pin block
`ifndef EPG_REGS_SVH
`define EPG_REGS_SVH
`define EPG_OFF_PIN_CFG 12'h028
`define EPG_OFF_WAKE_EN 12'h02C
`define EPG_OFF_HARDWARE_CONFIGURATION 12'h030
`define EPG_OFF_IRQ_STS 12'h034
`define EPG_OFF_IRQ_MSK 12'h038
`define EPG_OFF_WAKE_STS 12'h03C
`define EPG_FSEL_LSB 24
`define EPG_DRV_LSB 16
`define EPG_DIR_LSB 8
`define EPG_LVL_LSB 0
`define EPG_WPOL_LSB 8
`define EPG_RST_FSEL 8'hFF
`define EPG_RST_DRV 8'h00
`define EPG_RST_DIR 8'h00
`define EPG_RST_OUT 8'h00
`define EPG_RST_WAKE 16'h0000
`define EPG_RST_MSK 8'h00
`define EPG_HW_IME_BIT 0
`endif

//--- hdl/epg_pkg.sv
// types of the pin block
package epg_pkg;
   typedef struct packed {
      logic [7:0] fsel;
      logic [7:0] drv;
      logic [7:0] dir;
      logic [7:0] dout;
      logic [7:0] wake_en;
      logic [7:0] wake_pol;
      logic internal_signal_mirror_enable;
      logic [7:0] irq_sts;
      logic [7:0] irq_msk;
      logic [7:0] wake_sts;
      logic [7:0] pin_last;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic wake;
      logic [7:0] pad_out;
      logic [7:0] pad_oe;
   } epg_state_s;
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } epg_pad_s;
endpackage

//--- hdl/epg_pad.sv
// one pad: selects general-purpose or mirrored drive
`timescale 1ns/1ps
module epg_pad (
   input wire logic fsel,
   input wire logic drv,
   input wire logic dir,
   input wire logic dout,
   input wire logic internal_signal_mirror_enable,
   input wire logic mirror,
   input wire logic ext_mii,
   output logic out,
   output logic oe
);
   always_comb begin
      out = 1'b0;
      oe = 1'b0;
      if (!fsel && !ext_mii) begin
         if (dir) begin
            out = dout;
            oe = drv ? 1'b1 : !dout;
         end
      end else if (internal_signal_mirror_enable && !ext_mii) begin
         out = mirror;
         oe = 1'b1;
      end
   end
endmodule

//--- hdl/epg_top.sv
// eight-pin general-purpose port with APB registers
`timescale 1ns/1ps
`include "epg_regs.svh"
//
// Operation
// - function-select bit one gives default function, zero gives general use
// - all function-select bits reset to one
// - unselected pins may mirror internal signals when mirror enable set
// - drive-type bit set push/pull, clear open-drain; resets zero
// - direction bit set output, clear input; resets zero
// - written data bit drives an output pin
// - data bit read returns sampled pin level
// - wake needs input pin plus wake-enable bit
// - external interface mode makes all pins unavailable
module epg_top
   import epg_pkg::*;
#(
   parameter int NPINS = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] pad_in,
   input wire logic [7:0] mii_mirror,
   input wire logic ext_mii_mode,
   output logic [7:0] pad_out,
   output logic [7:0] pad_oe,
   output logic irq,
   output logic wake
);
   // ------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------
   if (NPINS != 8) begin : g_chk
      $error("epg_top serves exactly eight pins");
   end
   if (`EPG_FSEL_LSB + NPINS > 32) begin : g_chk_fsel
      $error("function-select field leaves the data word");
   end
   if (`EPG_DRV_LSB + NPINS > `EPG_FSEL_LSB) begin : g_chk_drv
      $error("drive-type field overlaps function select");
   end
   if (`EPG_DIR_LSB + NPINS > `EPG_DRV_LSB) begin : g_chk_dir
      $error("direction field overlaps drive type");
   end
   if (`EPG_LVL_LSB + NPINS > `EPG_DIR_LSB) begin : g_chk_lvl
      $error("level field overlaps direction");
   end
   if (((`EPG_OFF_PIN_CFG | `EPG_OFF_WAKE_EN | `EPG_OFF_HARDWARE_CONFIGURATION |
         `EPG_OFF_IRQ_STS | `EPG_OFF_IRQ_MSK | `EPG_OFF_WAKE_STS) &
        12'h003) != 12'h000) begin : g_chk_align
      $error("register offsets must be word aligned");
   end

   epg_state_s s_q;
   epg_state_s s_d;
   wire epg_pad_s pad_w;
   logic [7:0] fsel_eff;
   logic [7:0] in_pin;
   logic [7:0] edge_ev;
   logic [7:0] into_pol;
   logic [7:0] wake_ev;
   logic wr_acc;
   logic rd_acc;
   logic ans_go;
   logic wr_pin_cfg;
   logic wr_wake_cfg;
   logic wr_hardware_configuration;
   logic wr_irq_sts;
   logic wr_irq_msk;
   logic wr_wake_sts;
   logic [31:0] rd_word;
   logic hit;

   // ------------------------------------------------------------
   // pad drivers
   // ------------------------------------------------------------
   for (genvar i = 0; i < NPINS; i++) begin : g_pad
      epg_pad u_pad (
         .fsel(s_q.fsel[i]),
         .drv(s_q.drv[i]),
         .dir(s_q.dir[i]),
         .dout(s_q.dout[i]),
         .internal_signal_mirror_enable(s_q.internal_signal_mirror_enable),
         .mirror(mii_mirror[i]),
         .ext_mii(ext_mii_mode),
         .out(pad_w.out[i]),
         .oe(pad_w.oe[i])
      );
   end

   // ------------------------------------------------------------
   // events
   // ------------------------------------------------------------
   always_comb begin
      fsel_eff = s_q.fsel | {8{ext_mii_mode}};
      // only input, general-purpose pins take part
      in_pin = ~fsel_eff & ~s_q.dir;
      edge_ev = in_pin & (pad_in ^ s_q.pin_last);
      // pin now sits at the chosen wake polarity
      into_pol = ~(pad_in ^ s_q.wake_pol);
      wake_ev = edge_ev & s_q.wake_en & into_pol;
   end

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // a write lands at the edge that samples pready high
   assign wr_acc = psel && penable && pwrite && s_q.pready;
   assign rd_acc = psel && !penable && !pwrite;
   assign ans_go = psel && penable && !s_q.pready;

   // ------------------------------------------------------------
   // register write strobes
   // ------------------------------------------------------------
   always_comb begin
      wr_pin_cfg = 1'b0;
      wr_wake_cfg = 1'b0;
      wr_hardware_configuration = 1'b0;
      wr_irq_sts = 1'b0;
      wr_irq_msk = 1'b0;
      wr_wake_sts = 1'b0;
      if (wr_acc) begin
         // unmapped offsets raise no strobe
         unique case (paddr)
            `EPG_OFF_PIN_CFG: begin
               wr_pin_cfg = 1'b1;
            end
            `EPG_OFF_WAKE_EN: begin
               wr_wake_cfg = 1'b1;
            end
            `EPG_OFF_HARDWARE_CONFIGURATION: begin
               wr_hardware_configuration = 1'b1;
            end
            `EPG_OFF_IRQ_STS: begin
               wr_irq_sts = 1'b1;
            end
            `EPG_OFF_IRQ_MSK: begin
               wr_irq_msk = 1'b1;
            end
            `EPG_OFF_WAKE_STS: begin
               wr_wake_sts = 1'b1;
            end
            default: begin
               wr_pin_cfg = 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (paddr)
         `EPG_OFF_PIN_CFG: begin
            rd_word[`EPG_FSEL_LSB +: 8] = s_q.fsel;
            rd_word[`EPG_DRV_LSB +: 8] = s_q.drv;
            rd_word[`EPG_DIR_LSB +: 8] = s_q.dir;
            // live pins, not the written data
            rd_word[`EPG_LVL_LSB +: 8] = pad_in;
         end
         `EPG_OFF_WAKE_EN: begin
            rd_word[7:0] = s_q.wake_en;
            rd_word[`EPG_WPOL_LSB +: 8] = s_q.wake_pol;
         end
         `EPG_OFF_HARDWARE_CONFIGURATION: begin
            rd_word[`EPG_HW_IME_BIT] = s_q.internal_signal_mirror_enable;
         end
         `EPG_OFF_IRQ_STS: begin
            rd_word[7:0] = s_q.irq_sts;
         end
         `EPG_OFF_IRQ_MSK: begin
            rd_word[7:0] = s_q.irq_msk;
         end
         `EPG_OFF_WAKE_STS: begin
            rd_word[7:0] = s_q.wake_sts;
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   // ------------------------------------------------------------
   // address map
   // ------------------------------------------------------------
   always_comb begin
      hit = 1'b1;
      unique case (paddr)
         `EPG_OFF_PIN_CFG, `EPG_OFF_WAKE_EN, `EPG_OFF_HARDWARE_CONFIGURATION,
         `EPG_OFF_IRQ_STS, `EPG_OFF_IRQ_MSK, `EPG_OFF_WAKE_STS: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.pin_last = pad_in;
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      if (wr_pin_cfg && pstrb[3]) begin
         s_d.fsel = pwdata[`EPG_FSEL_LSB +: 8];
      end
      if (wr_pin_cfg && pstrb[2]) begin
         s_d.drv = pwdata[`EPG_DRV_LSB +: 8];
      end
      if (wr_pin_cfg && pstrb[1]) begin
         s_d.dir = pwdata[`EPG_DIR_LSB +: 8];
      end
      if (wr_pin_cfg && pstrb[0]) begin
         s_d.dout = pwdata[`EPG_LVL_LSB +: 8];
      end
      if (wr_wake_cfg && pstrb[0]) begin
         s_d.wake_en = pwdata[7:0];
      end
      if (wr_wake_cfg && pstrb[1]) begin
         s_d.wake_pol = pwdata[`EPG_WPOL_LSB +: 8];
      end
      if (wr_hardware_configuration && pstrb[0]) begin
         s_d.internal_signal_mirror_enable = pwdata[`EPG_HW_IME_BIT];
      end
      if (wr_irq_msk && pstrb[0]) begin
         s_d.irq_msk = pwdata[7:0];
      end
      // write one to clear
      if (wr_irq_sts && pstrb[0]) begin
         s_d.irq_sts = s_q.irq_sts & ~pwdata[7:0];
      end
      if (wr_wake_sts && pstrb[0]) begin
         s_d.wake_sts = s_q.wake_sts & ~pwdata[7:0];
      end
      // set wins over a same-cycle clear
      s_d.irq_sts = s_d.irq_sts | edge_ev;
      s_d.wake_sts = s_d.wake_sts | wake_ev;
      // read data stands from its setup cycle to the next read
      if (rd_acc) begin
         s_d.prdata = rd_word;
      end
      if (ans_go) begin
         s_d.pready = 1'b1;
         s_d.pslverr = !hit;
      end
      s_d.irq = |(s_d.irq_sts & s_d.irq_msk);
      s_d.wake = |s_d.wake_sts;
      // pads follow the registers one cycle later
      s_d.pad_out = pad_w.out;
      s_d.pad_oe = pad_w.oe;
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // every field at its reset value
         s_q.internal_signal_mirror_enable <= 1'b0;
         s_q.irq_sts <= '0;
         s_q.wake_sts <= '0;
         s_q.pin_last <= '0;
         s_q.prdata <= '0;
         s_q.pready <= 1'b0;
         s_q.pslverr <= 1'b0;
         s_q.irq <= 1'b0;
         s_q.wake <= 1'b0;
         s_q.pad_out <= '0;
         s_q.pad_oe <= '0;
         s_q.fsel <= `EPG_RST_FSEL;
         s_q.drv <= `EPG_RST_DRV;
         s_q.dir <= `EPG_RST_DIR;
         s_q.dout <= `EPG_RST_OUT;
         s_q.irq_msk <= `EPG_RST_MSK;
         {s_q.wake_pol, s_q.wake_en} <= `EPG_RST_WAKE;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign pad_out = s_q.pad_out;
   assign pad_oe = s_q.pad_oe;
   assign irq = s_q.irq;
   assign wake = s_q.wake;
endmodule

//--- test/epg_checker.sv
// port assertions of the pin block
`timescale 1ns/1ps
module epg_checker
   import epg_pkg::*;
#(
   parameter int NPINS = 8
) (
   input wire logic pclk, presetn, clk_en, psel, penable, pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready, pslverr,
   input wire logic [7:0] pad_in, mii_mirror,
   input wire logic ext_mii_mode,
   input wire logic [7:0] pad_out, pad_oe,
   input wire logic irq, wake
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // first access cycle of a transfer
   sequence s_acc;
      psel && penable && !pready && clk_en;
   endsequence
   property p_ans; s_acc |=> pready; endproperty
   a_ans: assert property (p_ans) else $error("late answer");
   property p_pls; pready |=> !pready; endproperty
   a_pls: assert property (p_pls) else $error("ready too long");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_idle; !(psel && penable) |=> !pready; endproperty
   a_idle: assert property (p_idle) else $error("ready unasked");
   property p_map; pready && paddr == 12'h028 |-> !pslverr; endproperty
   a_map: assert property (p_map) else $error("mapped refused");
   property p_unm; pready && paddr == 12'h040 |-> pslverr; endproperty
   a_unm: assert property (p_unm) else $error("unmapped accepted");
   property p_ext; ext_mii_mode [*3] |-> pad_oe == 8'h00; endproperty
   a_ext: assert property (p_ext) else $error("pad driven");
   property p_rst; $rose(presetn) |-> pad_oe == 8'h00 && !irq; endproperty
   a_rst: assert property (p_rst) else $error("reset state");
endmodule
bind epg_top epg_checker #(.NPINS(NPINS)) epg_checker_inst (.pclk(pclk),
   .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
   .mii_mirror(mii_mirror), .ext_mii_mode(ext_mii_mode),
   .pad_out(pad_out), .pad_oe(pad_oe), .irq(irq), .wake(wake));

//--- test/epg_top_test.sv
// self-checking bench of the pin block
`timescale 1ns/1ps
module epg_top_test;
   import epg_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic ext = 0, pready, pslverr, irq, wake, er;
   logic clk_en = 1;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [7:0] pin = 8'h5A, mir = 8'h3C, pad_out, pad_oe;
   int n_mismatch = 0, n_tests = 0;
   always #10 pclk = ~pclk;
   epg_top epg_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pad_in(pin), .mii_mirror(mir),
      .ext_mii_mode(ext), .pad_out(pad_out), .pad_oe(pad_oe), .irq(irq),
      .wake(wake));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d = 0);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i >= 20) begin
         n_mismatch++;
         stop_test();
      end
   endtask
   task automatic st();
      repeat (4) @(posedge pclk);
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 12'h028);
      cmp("cfg", 32'hFF00005A, rd);
      apb(1, 12'h028, 32'h00FFFFA5);
      st();
      cmp("out", 8'hA5, pad_out);
      cmp("oe", 8'hFF, pad_oe);
      apb(0, 12'h028);
      cmp("cfg", 32'h00FFFF5A, rd);
      apb(1, 12'h028, 32'h0000FFA5);
      st();
      cmp("oe", 8'h5A, pad_oe);
      $display("test drive done");
      apb(1, 12'h030, 1);
      apb(1, 12'h028, 32'hFF000000);
      st();
      cmp("oe", 8'hFF, pad_oe);
      cmp("out", 8'h3C, pad_out);
      ext <= 1'b1;
      st();
      cmp("oe", 0, pad_oe);
      ext <= 1'b0;
      $display("test mirror done");
      apb(1, 12'h028, 0);
      apb(1, 12'h038, 1);
      apb(1, 12'h02C, 32'h0202);
      pin <= 8'h58;
      st();
      pin <= 8'h5B;
      st();
      cmp("irq", 1, irq);
      cmp("wake", 1, wake);
      apb(0, 12'h034);
      cmp("sts", 32'h03, rd);
      apb(1, 12'h034, 1);
      apb(1, 12'h03C, 8'hFF);
      pin <= 8'h5F;
      st();
      cmp("irq", 0, irq);
      cmp("wake", 0, wake);
      clk_en <= 1'b0;
      pin <= 8'h5E;
      st();
      cmp("irq", 0, irq);
      clk_en <= 1'b1;
      st();
      cmp("irq", 1, irq);
      $display("test freeze done");
      apb(1, 12'h028, 32'h0000FF00);
      apb(1, 12'h034, 8'hFF);
      pin <= 8'h00;
      st();
      apb(0, 12'h034);
      cmp("sts", 0, rd);
      $display("test events done");
      apb(0, 12'h040);
      cmp("err", 1, er);
      $display("test unmapped done");
      stop_test();
   end
endmodule
